// ===== design/gpio_pkg.sv
package gpio_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PIN_LEVEL_OFFSET    = 8'h0e;
  localparam logic [7:0] INPUT_ENABLE_OFFSET = 8'h0f;
  localparam logic [7:0] PIN0_CONFIG_OFFSET  = 8'h10;
  localparam logic [7:0] PIN6_CONFIG_OFFSET  = 8'h16;
  localparam logic [7:0] PULLDOWN_OFFSET     = 8'hbe;

  // ==========================================================
  // Pin counts and positions
  localparam int          PIN_COUNT      = 7;
  localparam int          OPEN_DRAIN_PIN = 3;
  localparam logic [6:0]  PIN_MASK       = 7'h77;

  // ==========================================================
  // Reset values
  localparam logic [7:0] INPUT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PULLDOWN_RESET     = 8'h00;
  localparam logic [7:0] PIN_CONFIG_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ==========================================================
  // Source select codes
  localparam logic [2:0] SRC_RX_PORT0 = 3'h0;
  localparam logic [2:0] SRC_RX_PORT1 = 3'h1;
  localparam logic [2:0] SRC_DEVICE   = 3'h4;
  localparam logic [2:0] SRC_CSI_TX   = 3'h5;

  // ==========================================================
  // Function select codes
  localparam logic [2:0] FN_LOCK        = 3'h4;
  localparam logic [2:0] FN_PASS        = 3'h5;
  localparam logic [2:0] FN_FRAME_VALID = 3'h6;
  localparam logic [2:0] FN_LINE_VALID  = 3'h7;
  localparam logic [2:0] FN_DEV_LEVEL   = 3'h0;
  localparam logic [2:0] FN_DEV_LOCK_OR = 3'h1;
  localparam logic [2:0] FN_DEV_LOCK_AND = 3'h2;
  localparam logic [2:0] FN_DEV_PASS_AND = 3'h3;
  localparam logic [2:0] FN_DEV_FSYNC   = 3'h4;
  localparam logic [2:0] FN_DEV_IRQ_HI  = 3'h5;
  localparam logic [2:0] FN_DEV_IRQ_LO  = 3'h6;
  localparam logic [2:0] FN_CSI_PASS_AND = 3'h0;
  localparam logic [2:0] FN_CSI_PASS_OR  = 3'h1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [2:0] output_function_select;
    logic [2:0] output_source_select;
    logic       output_level_value;
    logic       output_drive_enable;
  } pin_config_type;

  typedef struct packed {
    logic [3:0] remote_gpio;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } rx_status_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } reg_req_type;

endpackage

// ===== design/gpio_pin_control.sv
`timescale 1ns/100ps

// Contract
// - Seven pins 0..6 are configured and observed in registers 0x0E..0x16 and 0xBE.
// - Pin 3 is an active-low open-drain pin sharing the interrupt pad.
// - After reset every pin is an input with input path on; pulldown is on for all pins but 3.
// - Pins other than 3 have input-disable bits at 0x0F, pulldown at 0xBE.
// - Writing 1 to bit n of 0x0F disables the input of pin n.
// - 0x0E reads the level of every pin, input or output alike.
// - Pin n has its own output config register at 0x10 plus n.
// - Config holds function 7:5, source 4:2, level 1, enable 0.
// - Source 000, functions 000..011 drive port 0 remote signals 0..3.
// - Source 000, functions 100..111 drive port 0 lock/pass/FV/LV.
// - Source 001 selects the same signals from receive port 1.
// - Source 100 function 000 drives the level bit onto the pin.
// - Source 100 functions 101/110 drive the interrupt high/low active.
module gpio_pin_control
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 resetn_in,
  // Register access port
  input  wire reg_req_type          reg_req_in,
  output logic [7:0]                reg_rdata_out,
  // Status sources
  input  wire rx_status_type        rx0_status_in,
  input  wire rx_status_type        rx1_status_in,
  input  wire logic [1:0]           rx_port_enable_in,
  input  wire logic                 frame_sync_in,
  input  wire logic                 device_irq_in,
  // Pads
  input  wire logic [PIN_COUNT-1:0] pin_level_in,
  output logic [PIN_COUNT-1:0]      pin_drive_out,
  output logic [PIN_COUNT-1:0]      pin_oe_out,
  output logic [PIN_COUNT-1:0]      pin_input_en_out,
  output logic [PIN_COUNT-1:0]      pin_pulldown_en_out
);

  // ==========================================================
  // Output value for one pin
  function automatic logic pin_value(
    input pin_config_type cfg,
    input rx_status_type  rx0,
    input rx_status_type  rx1,
    input logic [1:0]     port_en,
    input logic           fsync,
    input logic           irq
  );
    rx_status_type rx;
    logic [1:0]    lock_v;
    logic [1:0]    pass_v;
    logic          v;
    rx     = (cfg.output_source_select == SRC_RX_PORT1) ? rx1 : rx0;
    lock_v = {rx1.lock, rx0.lock} & port_en;
    pass_v = {rx1.pass, rx0.pass} | ~port_en;
    v      = 1'b0;
    case (cfg.output_source_select)
      SRC_RX_PORT0, SRC_RX_PORT1:
      begin
        case (cfg.output_function_select)
          FN_LOCK:        v = rx.lock;
          FN_PASS:        v = rx.pass;
          FN_FRAME_VALID: v = rx.frame_valid;
          FN_LINE_VALID:  v = rx.line_valid;
          default:        v = rx.remote_gpio[cfg.output_function_select[1:0]];
        endcase
      end
      SRC_DEVICE:
      begin
        case (cfg.output_function_select)
          FN_DEV_LEVEL:    v = cfg.output_level_value;
          FN_DEV_LOCK_OR:  v = |lock_v;
          FN_DEV_LOCK_AND: v = (lock_v == port_en) && (port_en != 2'h0);
          FN_DEV_PASS_AND: v = &pass_v;
          FN_DEV_FSYNC:    v = fsync;
          FN_DEV_IRQ_HI:   v = irq;
          FN_DEV_IRQ_LO:   v = ~irq;
          default:         v = 1'b0;
        endcase
      end
      SRC_CSI_TX:
      begin
        case (cfg.output_function_select)
          FN_CSI_PASS_AND: v = &pass_v;
          FN_CSI_PASS_OR:  v = |({rx1.pass, rx0.pass} & port_en);
          default:         v = 1'b0;
        endcase
      end
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Pad input synchroniser
  logic [PIN_COUNT-1:0] pin_meta_r;
  logic [PIN_COUNT-1:0] pin_sync_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_level_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================
  // Register file
  logic [PIN_COUNT-1:0] input_disable_r;
  logic [PIN_COUNT-1:0] input_disable_nxt;
  logic [PIN_COUNT-1:0] pulldown_disable_r;
  logic [PIN_COUNT-1:0] pulldown_disable_nxt;
  pin_config_type       pin_config_r   [PIN_COUNT];
  pin_config_type       pin_config_nxt [PIN_COUNT];
  logic [7:0]           reg_rdata_r;
  logic [7:0]           reg_rdata_nxt;

  always_comb
  begin
    input_disable_nxt    = input_disable_r;
    pulldown_disable_nxt = pulldown_disable_r;
    pin_config_nxt       = pin_config_r;
    reg_rdata_nxt        = reg_rdata_r;
    if (reg_req_in.write)
    begin
      // Pin 3 has no input or pulldown control, so its bit never sticks
      if (reg_req_in.addr == INPUT_ENABLE_OFFSET)
        input_disable_nxt = reg_req_in.wdata[6:0] & PIN_MASK;
      if (reg_req_in.addr == PULLDOWN_OFFSET)
        pulldown_disable_nxt = reg_req_in.wdata[6:0] & PIN_MASK;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        if (reg_req_in.addr == PIN0_CONFIG_OFFSET + 8'(i))
          pin_config_nxt[i] = pin_config_type'(reg_req_in.wdata);
      end
    end
    if (reg_req_in.read)
    begin
      reg_rdata_nxt = UNMAPPED_READ;
      case (reg_req_in.addr)
        PIN_LEVEL_OFFSET:    reg_rdata_nxt = {1'b0, pin_sync_r};
        INPUT_ENABLE_OFFSET: reg_rdata_nxt = {1'b0, input_disable_r};
        PULLDOWN_OFFSET:     reg_rdata_nxt = {1'b0, pulldown_disable_r};
        default:
        begin
          for (int i = 0; i < PIN_COUNT; i++)
          begin
            if (reg_req_in.addr == PIN0_CONFIG_OFFSET + 8'(i))
              reg_rdata_nxt = pin_config_r[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      input_disable_r    <= INPUT_ENABLE_RESET[6:0];
      pulldown_disable_r <= PULLDOWN_RESET[6:0];
      reg_rdata_r        <= UNMAPPED_READ;
      for (int i = 0; i < PIN_COUNT; i++)
        pin_config_r[i] <= pin_config_type'(PIN_CONFIG_RESET);
    end
    else
    begin
      input_disable_r    <= input_disable_nxt;
      pulldown_disable_r <= pulldown_disable_nxt;
      reg_rdata_r        <= reg_rdata_nxt;
      pin_config_r       <= pin_config_nxt;
    end
  end

  // ==========================================================
  // Pad drive
  logic [PIN_COUNT-1:0] drive_r;
  logic [PIN_COUNT-1:0] drive_nxt;
  logic [PIN_COUNT-1:0] oe_r;
  logic [PIN_COUNT-1:0] oe_nxt;
  logic [PIN_COUNT-1:0] in_en_r;
  logic [PIN_COUNT-1:0] in_en_nxt;
  logic [PIN_COUNT-1:0] pd_en_r;
  logic [PIN_COUNT-1:0] pd_en_nxt;

  always_comb
  begin
    logic v;
    v = 1'b0;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      v = pin_value(pin_config_r[i], rx0_status_in, rx1_status_in,
                    rx_port_enable_in, frame_sync_in, device_irq_in);
      // Output is re-evaluated every cycle while enabled
      drive_nxt[i] = v;
      oe_nxt[i]    = pin_config_r[i].output_drive_enable;
      // Input kept on under output so readback still sees the pad
      in_en_nxt[i] = ~input_disable_r[i];
      pd_en_nxt[i] = ~pulldown_disable_r[i] & ~oe_nxt[i];
    end
    // Open drain: only ever pulls low; idle pad carries the interrupt
    drive_nxt[OPEN_DRAIN_PIN] = 1'b0;
    oe_nxt[OPEN_DRAIN_PIN] = pin_config_r[OPEN_DRAIN_PIN].output_drive_enable
      ? ~pin_value(pin_config_r[OPEN_DRAIN_PIN], rx0_status_in,
                   rx1_status_in, rx_port_enable_in, frame_sync_in,
                   device_irq_in)
      : device_irq_in;
    in_en_nxt[OPEN_DRAIN_PIN] = 1'b1;
    pd_en_nxt[OPEN_DRAIN_PIN] = 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      drive_r <= '0;
      oe_r    <= '0;
      in_en_r <= '1;
      pd_en_r <= PIN_MASK;
    end
    else
    begin
      drive_r <= drive_nxt;
      oe_r    <= oe_nxt;
      in_en_r <= in_en_nxt;
      pd_en_r <= pd_en_nxt;
    end
  end

  assign reg_rdata_out       = reg_rdata_r;
  assign pin_drive_out       = drive_r;
  assign pin_oe_out          = oe_r;
  assign pin_input_en_out    = in_en_r;
  assign pin_pulldown_en_out = pd_en_r;

endmodule

// ===== tb/gpio_pin_control_checker.sv
`timescale 1ns/100ps

module gpio_pin_control_checker
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic                 sys_clk_in,
  input wire logic                 resetn_in,
  // Watched ports
  input wire reg_req_type          reg_req_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire rx_status_type        rx0_status_in,
  input wire logic                 device_irq_in,
  input wire logic [PIN_COUNT-1:0] pin_drive_out,
  input wire logic [PIN_COUNT-1:0] pin_oe_out,
  input wire logic [PIN_COUNT-1:0] pin_input_en_out,
  input wire logic [PIN_COUNT-1:0] pin_pulldown_en_out
);
  // ==========
  // Shadow of pin 1 config
  logic [7:0] cfg1_r;
  logic [7:0] cfg1_nxt;
  logic       wr_in;
  assign wr_in = reg_req_in.write;
  always_comb
    cfg1_nxt = (wr_in && reg_req_in.addr == 8'h11) ? reg_req_in.wdata : cfg1_r;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in)
      cfg1_r <= 8'h00;
    else
      cfg1_r <= cfg1_nxt;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  reset_vals_a: assert property ($rose(resetn_in) |->
    pin_input_en_out == 7'h7f && pin_pulldown_en_out == PIN_MASK
    && (pin_oe_out & 7'h77) == 7'h00) else $error("reset pad state wrong");
  pin_three_a: assert property (pin_input_en_out[3] && !pin_drive_out[3]
    && !pin_pulldown_en_out[3]) else $error("pin three not open drain");
  input_disable_a: assert property (wr_in
    && reg_req_in.addr == INPUT_ENABLE_OFFSET |-> ##2 pin_input_en_out ==
    (~$past(reg_req_in.wdata[6:0], 2) | 7'h08)) else $error("input enable");
  level_drive_a: assert property (wr_in && reg_req_in.addr == 8'h10
    && reg_req_in.wdata[7:2] == 6'h04 && reg_req_in.wdata[0] |-> ##2
    pin_oe_out[0] && pin_drive_out[0] == $past(reg_req_in.wdata[1], 2))
    else $error("level drive wrong");
  drive_off_a: assert property (wr_in && reg_req_in.addr == 8'h10
    && !reg_req_in.wdata[0] |-> ##2 !pin_oe_out[0]) else $error("drive on");
  lock_follow_a: assert property (cfg1_r == 8'h81
    && $past(cfg1_r) == 8'h81 |-> pin_oe_out[1] && pin_drive_out[1] ==
    $past(rx0_status_in.lock)) else $error("lock not followed");
  irq_low_a: assert property (cfg1_r == 8'hd1 && $past(cfg1_r) == 8'hd1
    |-> pin_drive_out[1] == !$past(device_irq_in)) else $error("irq low");
  pulldown_off_a: assert property ((pin_oe_out & pin_pulldown_en_out)
    == 7'h00) else $error("pulldown on while driving");
  unmapped_read_a: assert property (reg_req_in.read
    && reg_req_in.addr == 8'h20 |=> reg_rdata_out == UNMAPPED_READ)
    else $error("unmapped read not zero");
endmodule

bind gpio_pin_control gpio_pin_control_checker chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out), .rx0_status_in(rx0_status_in),
  .device_irq_in(device_irq_in), .pin_drive_out(pin_drive_out),
  .pin_oe_out(pin_oe_out), .pin_input_en_out(pin_input_en_out),
  .pin_pulldown_en_out(pin_pulldown_en_out));

// ===== tb/gpio_pad_board.sv
`timescale 1ns/100ps

module gpio_pad_board
  import gpio_pkg::*;
(
  // Device side
  input  wire logic [6:0] oe_in,
  input  wire logic [6:0] drive_in,
  input  wire logic [6:0] pd_en_in,
  // Board side
  input  wire logic [6:0] ext_oe_in,
  input  wire logic [6:0] ext_val_in,
  output logic [6:0]      level_out
);
  // ==========
  // Floating pads never echo the last value
  always_comb
    for (int i = 0; i < PIN_COUNT; i++)
      if (oe_in[i])
        level_out[i] = (i == OPEN_DRAIN_PIN) ? 1'b0 : drive_in[i];
      else if (ext_oe_in[i])
        level_out[i] = ext_val_in[i];
      else if (i == OPEN_DRAIN_PIN)
        level_out[i] = 1'b1;
      else
        level_out[i] = pd_en_in[i] ? 1'b0 : ~ext_val_in[i];
endmodule

// ===== tb/deser_gpio_pin_control_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module deser_gpio_pin_control_tb;
  import gpio_pkg::*;
  logic           sys_clk_in;
  logic           resetn_in;
  reg_req_type    req;
  logic [7:0]     rdata;
  rx_status_type  rx0, rx1;
  logic           irq;
  logic [6:0]     lvl, drv, oe, ien, pden, ext_oe, ext_val, e_bits;
  logic [15:0]    exp_q[$];
  logic [15:0]    note;
  logic [31:0]    s;
  logic           rd_d1 = 1'b0;
  int             err_count = 0, cmp_count = 0, cycles = 0;
  int             seed = 32'h0a9e;
  pin_config_type cfg [PIN_COUNT];

  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  gpio_pin_control DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .rx0_status_in(rx0),
    .rx1_status_in(rx1), .rx_port_enable_in(2'b11), .frame_sync_in(1'b0),
    .device_irq_in(irq), .pin_level_in(lvl), .pin_drive_out(drv),
    .pin_oe_out(oe), .pin_input_en_out(ien), .pin_pulldown_en_out(pden));
  gpio_pad_board board (.oe_in(oe), .drive_in(drv), .pd_en_in(pden),
    .ext_oe_in(ext_oe), .ext_val_in(ext_val), .level_out(lvl));

  // ==========
  // Bus cycles and result watcher
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk_in);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back({m, e});
    @(posedge sys_clk_in);
    req <= '0;
  endtask
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic exp_bit(pin_config_type c);
    logic [7:0] v;
    v = (c.output_source_select == SRC_RX_PORT1) ? rx1 : rx0;
    if (c.output_source_select != SRC_DEVICE)
      return c.output_function_select[2] ? v[7 - c.output_function_select]
                                         : v[4 + c.output_function_select];
    if (c.output_function_select == FN_DEV_LEVEL)
      return c.output_level_value;
    return (c.output_function_select == FN_DEV_IRQ_HI) ? irq : !irq;
  endfunction

  always @(posedge sys_clk_in)
  begin
    if (rd_d1)
    begin
      note = exp_q.pop_front();
      `CHK("rdata", note[7:0] & note[15:8], rdata & note[15:8])
    end
    rd_d1 <= req.read;
    cycles++;
    if (cycles > 3000)
    begin
      err_count++;
      complete_run();
    end
  end

  initial
  begin
    resetn_in = 1'b0; req = '0; rx0 = '0; rx1 = '0; irq = 1'b0;
    ext_oe = 7'h7f; ext_val = 7'h5a;
    repeat (16) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    for (int a = 15; a <= 22; a++)
      rd(8'(a), 8'h00, 8'hff);
    rd(PULLDOWN_OFFSET, PULLDOWN_RESET, 8'hff);
    rd(8'h20, UNMAPPED_READ, 8'hff);
    rd(PIN_LEVEL_OFFSET, {1'b0, ext_val}, 8'hff);
    wr(INPUT_ENABLE_OFFSET, 8'hff);
    rd(INPUT_ENABLE_OFFSET, 8'h77, 8'hff);
    wr(PULLDOWN_OFFSET, 8'hff);
    rd(PULLDOWN_OFFSET, 8'h77, 8'hff);
    ext_oe <= 7'h00;
    for (int i = 0; i < 12; i++)
    begin
      for (int p = 0; p < PIN_COUNT; p++)
      begin
        s = $random(seed);
        cfg[p] = {s[2:0], s[3], 1'b0, s[4] & ~s[3], s[5], 1'b1};
        if (s[3])
          cfg[p].output_function_select = s[6] ? 3'h0 : (s[7] ? 3'h5 : 3'h6);
        if (i < 2 && p == 1)
          cfg[p] = (i == 0) ? 8'h81 : 8'hd1;
        if (i == 0 && p == 0)
          cfg[p] = 8'h13;
        wr(PIN0_CONFIG_OFFSET + 8'(p), cfg[p]);
      end
      rx0 <= rx_status_type'(8'($random(seed)));
      rx1 <= rx_status_type'(8'($random(seed)));
      irq <= 1'($random(seed));
      repeat (5) @(posedge sys_clk_in);
      for (int p = 0; p < PIN_COUNT; p++)
        e_bits[p] = exp_bit(cfg[p]);
      rd(PIN_LEVEL_OFFSET, {1'b0, e_bits}, 8'h7f);
      rd(PIN0_CONFIG_OFFSET + 8'(i % 7), cfg[i % 7], 8'hff);
    end
    irq <= 1'b0;
    ext_oe <= 7'h7f;
    ext_val <= 7'($random(seed));
    for (int p = 0; p < PIN_COUNT; p++)
      wr(PIN0_CONFIG_OFFSET + 8'(p), 8'hfe);
    repeat (5) @(posedge sys_clk_in);
    rd(PIN_LEVEL_OFFSET, {1'b0, ext_val}, 8'hff);
    repeat (3) @(posedge sys_clk_in);
    complete_run();
  end
endmodule
